// [logic/dcr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module dcr_top
	import dcr_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	// peripheral request sources, asynchronous
	input  wire logic [DCR_NSRC-1:0]  periph_req_i,
	// transfer starts
	output logic [1:0]                xfer_start_o
);
	import dcr_pkg::*;
	logic [DCR_NSRC-1:0] preq_s;
	logic [DCR_NSRC-1:0] preq_d_reg;
	logic [DCR_NSRC-1:0] preq_rise;
	dcr_ctl_t            ctl [2];
	dcr_sts_t            sts [2];
	logic [1:0]          sel_reg [2];
	logic                fwd_dst_reg [2];
	logic                size_reg [2];
	logic [DCR_AW-1:0]   src_reg [2];
	logic [DCR_AW-1:0]   dst_reg [2];
	logic [DCR_CW-1:0]   rld_reg [2];
	logic                wr;
	logic                ch;
	logic [3:0]          idx;
	logic [31:0]         rd_next;
	// =====================================================================
	// request sources synchronised and edge detected
	dcr_sync2 #(.W(DCR_NSRC)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (periph_req_i),
		.q_o   (preq_s)
	);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			preq_d_reg <= '0;
		end else begin
			preq_d_reg <= preq_s;
		end
	end
	assign preq_rise = preq_s & ~preq_d_reg;
	// =====================================================================
	// bus decode
	assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign ch  = wb_adr_i[DCR_CH_SHIFT];
	assign idx = wb_adr_i[5:2];
	// =====================================================================
	// configuration registers, one set per channel
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic hit;
		assign hit = wr && (ch == 1'(c));
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sel_reg[c]     <= 2'h0;
				fwd_dst_reg[c] <= 1'b0;
				size_reg[c]    <= 1'b0;
			end else if (hit && idx == DCR_IDX_CTRL && wb_sel_i[0]) begin
				sel_reg[c]     <= wb_dat_i[DCR_BIT_SEL_HI:DCR_BIT_SEL_LO];
				fwd_dst_reg[c] <= wb_dat_i[DCR_BIT_FWD_DST];
				size_reg[c]    <= wb_dat_i[DCR_BIT_SIZE];
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				src_reg[c] <= DCR_PTR_RST;
				dst_reg[c] <= DCR_PTR_RST;
				rld_reg[c] <= DCR_CNT_RST;
			end else if (hit && wb_sel_i == 4'hF) begin
				if (idx == DCR_IDX_SRC) src_reg[c] <= wb_dat_i[DCR_AW-1:0];
				if (idx == DCR_IDX_DST) dst_reg[c] <= wb_dat_i[DCR_AW-1:0];
				if (idx == DCR_IDX_RLD) rld_reg[c] <= wb_dat_i[DCR_CW-1:0];
			end
		end
		always_comb begin
			ctl[c]         = '0;
			ctl[c].en_wr1  = hit && idx == DCR_IDX_CTRL && wb_sel_i[0]
				&& wb_dat_i[DCR_BIT_EN];
			ctl[c].req_clr = hit && idx == DCR_IDX_CTRL && wb_sel_i[0]
				&& !wb_dat_i[DCR_BIT_REQ];
			ctl[c].sel_chg = hit && idx == DCR_IDX_CTRL && wb_sel_i[0]
				&& wb_dat_i[DCR_BIT_SEL_HI:DCR_BIT_SEL_LO] != sel_reg[c];
			ctl[c].sel     = sel_reg[c];
			ctl[c].fwd_dst = (hit && idx == DCR_IDX_CTRL && wb_sel_i[0])
				? wb_dat_i[DCR_BIT_FWD_DST] : fwd_dst_reg[c];
			ctl[c].src     = src_reg[c];
			ctl[c].dst     = dst_reg[c];
			ctl[c].rld     = rld_reg[c];
		end
		// a cause change raises a spurious request, as the real part may
		dcr_chan u_chan (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.ctl_i     (ctl[c]),
			.src_req_i (preq_rise[sel_reg[c]] || ctl[c].sel_chg),
			.sts_o     (sts[c])
		);
	end
	// =====================================================================
	// read mux
	always_comb begin
		rd_next = 32'h0000_0000;
		case (idx)
			DCR_IDX_CTRL: begin
				rd_next[DCR_BIT_SIZE]    = size_reg[ch];
				rd_next[DCR_BIT_FWD_DST] = fwd_dst_reg[ch];
				rd_next[DCR_BIT_REQ]     = sts[ch].req;
				rd_next[DCR_BIT_EN]      = sts[ch].en;
				rd_next[DCR_BIT_SEL_HI:DCR_BIT_SEL_LO] = sel_reg[ch];
			end
			DCR_IDX_SRC: rd_next[DCR_AW-1:0] = src_reg[ch];
			DCR_IDX_DST: rd_next[DCR_AW-1:0] = dst_reg[ch];
			DCR_IDX_RLD: rd_next[DCR_CW-1:0] = rld_reg[ch];
			DCR_IDX_FWD: rd_next[DCR_AW-1:0] = sts[ch].fwd;
			DCR_IDX_CNT: rd_next[DCR_CW-1:0] = sts[ch].cnt;
			default: rd_next = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_next;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xfer_start_o <= 2'b00;
		end else begin
			xfer_start_o <= {sts[1].start, sts[0].start};
		end
	end
endmodule : dcr_top
`default_nettype wire

// [logic/dcr_pkg.sv]
`default_nettype none
package dcr_pkg;
	// =====================================================================
	// widths
	localparam int DCR_AW = 20;
	localparam int DCR_CW = 16;
	localparam int DCR_NSRC = 4;
	// =====================================================================
	// control register bit positions
	localparam int DCR_BIT_SIZE = 0;
	localparam int DCR_BIT_FWD_DST = 1;
	localparam int DCR_BIT_REQ = 2;
	localparam int DCR_BIT_EN = 3;
	localparam int DCR_BIT_SEL_LO = 4;
	localparam int DCR_BIT_SEL_HI = 5;
	// =====================================================================
	// register word indices
	localparam logic [3:0] DCR_IDX_CTRL = 4'h0;
	localparam logic [3:0] DCR_IDX_SRC = 4'h1;
	localparam logic [3:0] DCR_IDX_DST = 4'h2;
	localparam logic [3:0] DCR_IDX_RLD = 4'h3;
	localparam logic [3:0] DCR_IDX_FWD = 4'h4;
	localparam logic [3:0] DCR_IDX_CNT = 4'h5;
	localparam logic [3:0] DCR_IDX_XFER = 4'h6;
	// byte address bit 6 picks channel
	localparam int DCR_CH_SHIFT = 6;
	// =====================================================================
	// reset values
	localparam logic [7:0] DCR_CTRL_RST = 8'h00;
	localparam logic [DCR_AW-1:0] DCR_PTR_RST = 20'h00000;
	localparam logic [DCR_CW-1:0] DCR_CNT_RST = 16'h0000;
	// =====================================================================
	// per-channel control carrier
	typedef struct packed {
		logic                  en_wr1;
		logic                  req_clr;
		logic                  sel_chg;
		logic [1:0]            sel;
		logic                  fwd_dst;
		logic [DCR_AW-1:0]     src;
		logic [DCR_AW-1:0]     dst;
		logic [DCR_CW-1:0]     rld;
	} dcr_ctl_t;
	typedef struct packed {
		logic                  en;
		logic                  req;
		logic [DCR_AW-1:0]     fwd;
		logic [DCR_CW-1:0]     cnt;
		logic                  start;
	} dcr_sts_t;
	typedef enum logic [1:0] {
		DCR_IDLE = 2'b00,
		DCR_ACT  = 2'b01
	} dcr_state_t;
endpackage : dcr_pkg
`default_nettype wire

// [logic/dcr_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module dcr_sync2 #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic [W-1:0]      q_o
);
	logic [W-1:0] s1_reg;
	if (W < 1) begin : g_bad_w
		$error("bad width");
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			q_o    <= '0;
		end else begin
			s1_reg <= d_i;
			q_o    <= s1_reg;
		end
	end
endmodule : dcr_sync2
`default_nettype wire

// [logic/dcr_chan.sv]
`timescale 1ns/10ps
`default_nettype none
module dcr_chan
	import dcr_pkg::*;
(
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	// control
	input  var  dcr_ctl_t  ctl_i,
	input  wire logic      src_req_i,
	// status
	output var dcr_sts_t   sts_o
);
	dcr_state_t state_reg;
	logic       req_reg;
	logic       start;
	logic [DCR_AW-1:0] fwd_reg;
	logic [DCR_CW-1:0] cnt_reg;
	// =====================================================================
	// enable state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= DCR_IDLE;
		end else if (ctl_i.en_wr1) begin
			state_reg <= DCR_ACT;
		end else if (start && cnt_reg == DCR_CNT_RST) begin
			state_reg <= DCR_IDLE;
		end
	end
	// transfer begins at once when active and requested, unless EN is written to 1 in that cycle
	assign start = (state_reg == DCR_ACT) && req_reg && !ctl_i.en_wr1;
	// =====================================================================
	// request flag: hardware set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_reg <= 1'b0;
		end else if (src_req_i) begin
			req_reg <= 1'b1;
		end else if (start) begin
			req_reg <= 1'b0;
		end else if (ctl_i.req_clr) begin
			req_reg <= 1'b0;
		end
	end
	// =====================================================================
	// pointer and counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_reg <= DCR_PTR_RST;
			cnt_reg <= DCR_CNT_RST;
		end else if (ctl_i.en_wr1) begin
			fwd_reg <= ctl_i.fwd_dst ? ctl_i.dst : ctl_i.src;
			cnt_reg <= ctl_i.rld;
		end else if (start) begin
			fwd_reg <= fwd_reg + DCR_AW'(1);
			cnt_reg <= cnt_reg - DCR_CW'(1);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sts_o <= '0;
		end else begin
			sts_o.en    <= (state_reg == DCR_ACT);
			sts_o.req   <= req_reg;
			sts_o.fwd   <= fwd_reg;
			sts_o.cnt   <= cnt_reg;
			sts_o.start <= start;
		end
	end
endmodule : dcr_chan
`default_nettype wire

// [bench/dcr_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module dcr_top_chk (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// watched ports
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [1:0]  xfer_start_o
);
	import dcr_pkg::*;
	// ======
	// bus and start checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic rd = rq && !wb_we_i;
	property p_ack_resp; rq |=> wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
	property p_ack_cause; $rose(wb_ack_o) |-> $past(rq); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack no cause");
	property p_hole;
		rd && wb_adr_i[5:2] >= DCR_IDX_XFER |=> wb_dat_o == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("hole not zero");
	property p_ctrl_hi;
		rd && wb_adr_i[5:2] == DCR_IDX_CTRL |=> wb_dat_o[31:6] == '0;
	endproperty
	a_ctrl_hi: assert property (p_ctrl_hi) else $error("ctrl high");
	property p_st0; xfer_start_o[0] |=> !xfer_start_o[0]; endproperty
	a_st0: assert property (p_st0) else $error("start0 long");
	property p_st1; xfer_start_o[1] |=> !xfer_start_o[1]; endproperty
	a_st1: assert property (p_st1) else $error("start1 long");
	c_wr: cover property (rq && wb_we_i);
	c_st0: cover property (xfer_start_o[0]);
	c_st1: cover property (xfer_start_o[1]);
endmodule : dcr_top_chk
bind dcr_top dcr_top_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .xfer_start_o);
`default_nettype wire

// [bench/dcr_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dcr_src_model
	import dcr_pkg::*;
(
	// clock
	input  wire logic                clk_i,
	// request sources, idle low
	output logic [DCR_NSRC-1:0]      periph_req_o
);
	// ======
	// one request: a rising edge held past the synchroniser
	initial periph_req_o = '0;
	task automatic fire(input int n);
		@(posedge clk_i);
		periph_req_o[n] <= 1'b1;
		repeat (3) @(posedge clk_i);
		periph_req_o[n] <= 1'b0;
	endtask : fire
endmodule : dcr_src_model
`default_nettype wire

// [bench/tb_dma_channel_request_enable.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_dma_channel_request_enable;
	import dcr_pkg::*;
	// ======
	// stimulus and dut
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [31:0] dat   = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dato;
	logic        ack;
	logic [3:0]  preq;
	logic [1:0]  xs;
	int          miscompares = 0;
	int          n_tests = 0;
	always #2.5 clk_i = ~clk_i;
	dcr_src_model src_u (.clk_i(clk_i), .periph_req_o(preq));
	dcr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
		.periph_req_i(preq), .xfer_start_o(xs));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge clk_i);
		if (ack !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		rdat = dato;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask : rc
	task automatic see_start(input int ch);
		int i;
		for (i = 0; i < 30 && xs[ch] !== 1'b1; i++)
			@(posedge clk_i);
		chk("start", 32'h1, {31'h0, xs[ch]});
		chk("other", 32'h0, {31'h0, xs[1-ch]});
		if (xs[ch] !== 1'b1)
			wrap_up();
	endtask : see_start
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rc("ctrl0", 8'h00, 32'h0);
		rc("fwd0", 8'h10, 32'h0);
		bus(1'b1, 8'h18, 32'hFF);
		rc("hole", 8'h18, 32'h0);
		bus(1'b1, 8'h04, 32'h12345);
		bus(1'b1, 8'h0C, 32'h3);
		bus(1'b1, 8'h00, 32'h10);
		bus(1'b1, 8'h00, 32'h10);
		rc("ctrl0", 8'h00, 32'h10);
		bus(1'b1, 8'h00, 32'h18);
		rc("fwd0", 8'h10, 32'h12345);
		rc("cnt0", 8'h14, 32'h3);
		fork src_u.fire(1); join_none
		see_start(0);
		rc("ctrl0", 8'h00, 32'h18);
		rc("fwd0", 8'h10, 32'h12346);
		rc("cnt0", 8'h14, 32'h2);
		bus(1'b1, 8'h00, 32'h18);
		rc("fwd0", 8'h10, 32'h12345);
		rc("cnt0", 8'h14, 32'h3);
		bus(1'b1, 8'h48, 32'hABCD);
		bus(1'b1, 8'h4C, 32'h5);
		bus(1'b1, 8'h40, 32'h20);
		bus(1'b1, 8'h40, 32'h20);
		fork src_u.fire(2); join_none
		repeat (10) @(posedge clk_i);
		rc("ctrl1", 8'h40, 32'h24);
		bus(1'b1, 8'h40, 32'h24);
		rc("ctrl1", 8'h40, 32'h24);
		bus(1'b1, 8'h40, 32'h20);
		rc("ctrl1", 8'h40, 32'h20);
		rc("ctrl0", 8'h00, 32'h18);
		fork src_u.fire(2); join_none
		repeat (10) @(posedge clk_i);
		bus(1'b1, 8'h40, 32'h2E);
		see_start(1);
		rc("fwd1", 8'h50, 32'hABCE);
		rc("cnt1", 8'h54, 32'h4);
		wrap_up();
	end
endmodule : tb_dma_channel_request_enable
`default_nettype wire
